// file: rtl/i2c_baud_gen.sv
// Baud rate generator: one-cycle tick every period+1 clocks while running.
// Assumes the caller holds reload high to restart a full interval.
`timescale 1ns/1ps
module i2c_baud_gen import i2c_pkg::*; #(
    parameter int W = BRG_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic reload,
    input wire logic [W-1:0] period,
    // Rate enable
    output logic tick
);

    logic [W-1:0] cnt;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (!run || reload || cnt == '0) begin
            cnt <= period;
        end else begin
            cnt <= cnt - W'(1);
        end
    end

    assign tick = run && !reload && cnt == '0;

endmodule // i2c_baud_gen

// file: rtl/i2c_ctrl.sv
// Two-wire bus master sequencer with slave address recognition.
// Assumes bus pins are open drain and already synchronous to mclk.
//
// Contract
// RQ1: Master event completion sets master event flag.
// RQ2: Address directed at us sets slave event flag.
// RQ3: Control bit disables slew limiting on both lines.
// RQ4: Accept-all mode matches every received address.
// RQ5: All-zero byte, write direction, is general call.
// RQ6: General call honoured only with control bit 7.
// RQ7: After start, shift eight bits, then compare.
// RQ8: General call: buffer, full flag, flag at ninth.
// RQ9: Software reads buffer to tell call types apart.
// RQ10: Six master commands: start, restart, send, stop, receive, ack.
// RQ11: Master makes every clock pulse, start, stop.
// RQ12: Repeated start keeps bus; only stop releases.
// RQ13: Transmit eight bits each, then sample acknowledge.
// RQ14: Receive answers each byte with driven acknowledge.
// RQ15: Transmit register write sends any byte alike.
// RQ16: Transmit write sets full flag, starts generator.
// RQ17: Software writes transmit register only while waiting.
// RQ18: Data bits change only after clock falls.
// RQ19: Status bit 14 high during master transmit.
// RQ20: Event flags set by hardware, cleared by software.
// RQ21: Start is data fall, stop data rise, clock high.
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module i2c_ctrl import i2c_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Avalon-MM register slave
    input wire av_req_t av_req,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Bus pins
    input wire pins_in_t pins_i,
    output pins_out_t pins_o
);

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [15:0] ctrl;
        logic [6:0] own;
        logic [7:0] trn;
        logic [7:0] rcv;
        logic [BRG_W-1:0] brg;
        logic transmit_full_flag;
        logic receive_full_flag;
        logic mev;
        logic sev;
        logic gcall;
        logic ackstat;
        logic transmit_in_progress;
        mst_state_t ms;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic owns_bus;
        logic scl_low;
        logic sda_low;
        logic scl_d;
        logic sda_d;
        logic sl_act;
        logic [3:0] sl_cnt;
        logic [7:0] rsr;
        logic sl_ack;
        logic sl_hit;
        logic sl_gc;
    } state_t;

    state_t st;
    state_t next_st;
    logic tick;
    logic brg_run;
    logic brg_reload;

    // ********************************
    // Helpers
    // ********************************
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    function automatic logic high_phase(input mst_state_t s);
        return s == M_START1 || s == M_RS2 || s == M_TXH || s == M_AKH ||
               s == M_RXH || s == M_AOH || s == M_SP2;
    endfunction

    // ********************************
    // Baud rate generator
    // ********************************
    // A slave holding the clock low reloads the count, so each high phase
    // lasts its full length once the line really is high.
    assign brg_run = st.ctrl[CTL_ENABLE] && st.ms != M_IDLE && st.ms != M_WAIT;
    assign brg_reload = high_phase(st.ms) && !pins_i.scl;

    i2c_baud_gen #(.W(BRG_W)) u_brg (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(brg_run),
        .reload(brg_reload),
        .period(st.brg),
        .tick(tick)
    );

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        logic bus_start;
        logic bus_stop;
        logic scl_fall;
        logic scl_rise;
        logic [15:0] wval;
        logic match_gc;
        logic match_own;
        bus_start = 1'b0;
        bus_stop = 1'b0;
        scl_fall = 1'b0;
        scl_rise = 1'b0;
        wval = 16'h0000;
        match_gc = 1'b0;
        match_own = 1'b0;
        next_st = st;

        // Register slave: one wait cycle, read data captured first, write
        // applied on the cycle the master sees waitrequest low.
        next_st.ack = (av_req.read || av_req.write) && !st.ack;
        if (av_req.read && !st.ack) begin
            case (av_req.address)
                OFF_CTRL: next_st.rdata = {16'h0000, st.ctrl};
                OFF_STAT: next_st.rdata = {16'h0000, st.ackstat, st.transmit_in_progress, 9'h000, st.gcall,
                                           st.sev, st.mev, st.receive_full_flag, st.transmit_full_flag}; // [RQ19]
                OFF_OWN: next_st.rdata = {25'h0000000, st.own};
                OFF_TRN: next_st.rdata = {24'h000000, st.trn};
                OFF_RCV: begin
                    next_st.rdata = {24'h000000, st.rcv}; // [RQ9]
                    next_st.receive_full_flag = 1'b0;
                end
                OFF_BRG: next_st.rdata = {{(32 - BRG_W){1'b0}}, st.brg};
                default: next_st.rdata = 32'h00000000;
            endcase
        end
        if (av_req.write && st.ack) begin
            wval = merge16(16'h0000, av_req.writedata, av_req.byteenable);
            case (av_req.address)
                OFF_CTRL: next_st.ctrl = merge16(st.ctrl, av_req.writedata, av_req.byteenable);
                OFF_STAT: begin
                    // Flags clear only by writing ones; hardware sets below win.
                    next_st.mev = st.mev && !wval[ST_MASTER_EV]; // [RQ20]
                    next_st.sev = st.sev && !wval[ST_SLAVE_EV]; // [RQ20]
                    next_st.gcall = st.gcall && !wval[ST_GCALL];
                end
                OFF_OWN: next_st.own = av_req.byteenable[0] ? av_req.writedata[6:0] : st.own;
                OFF_TRN: begin
                    if (av_req.byteenable[0]) begin
                        next_st.trn = av_req.writedata[7:0]; // [RQ15]
                        next_st.transmit_full_flag = 1'b1; // [RQ16]
                    end
                end
                OFF_BRG: next_st.brg = merge16(st.brg, av_req.writedata, av_req.byteenable);
                default: ;
            endcase
        end

        // Master sequencer. Every phase lasts one baud tick.
        if (!st.ctrl[CTL_ENABLE]) begin
            next_st.ms = M_IDLE;
            next_st.owns_bus = 1'b0;
            next_st.scl_low = 1'b0;
            next_st.sda_low = 1'b0;
            next_st.transmit_in_progress = 1'b0;
        end else begin
            case (st.ms)
                M_IDLE: begin
                    if (st.ctrl[CTL_START]) begin
                        next_st.ms = M_START1; // [RQ10]
                        next_st.scl_low = 1'b0;
                        next_st.sda_low = 1'b0;
                    end
                end
                M_START1: begin
                    if (tick) begin
                        next_st.sda_low = 1'b1; // [RQ21] [RQ11]
                        next_st.ms = M_START2;
                    end
                end
                M_START2: begin
                    if (tick) begin
                        next_st.scl_low = 1'b1;
                        next_st.ctrl[CTL_START] = 1'b0;
                        next_st.ctrl[CTL_RESTART] = 1'b0;
                        next_st.owns_bus = 1'b1;
                        next_st.mev = 1'b1; // [RQ1]
                        next_st.ms = M_WAIT;
                    end
                end
                M_WAIT: begin
                    // The clock stays low here, so the bus is held between
                    // bytes and across a repeated start.
                    if (st.ctrl[CTL_RESTART]) begin
                        next_st.sda_low = 1'b0; // [RQ10] [RQ12]
                        next_st.ms = M_RS1;
                    end else if (st.ctrl[CTL_STOP]) begin
                        next_st.sda_low = 1'b1; // [RQ10]
                        next_st.ms = M_SP1;
                    end else if (st.transmit_full_flag) begin
                        next_st.sh = st.trn; // [RQ10] [RQ13]
                        next_st.transmit_full_flag = 1'b0;
                        next_st.transmit_in_progress = 1'b1; // [RQ19]
                        next_st.bitn = TOP_BIT;
                        next_st.sda_low = !st.trn[7]; // [RQ18]
                        next_st.ms = M_TXL;
                    end else if (st.ctrl[CTL_RECV]) begin
                        next_st.sda_low = 1'b0; // [RQ10]
                        next_st.bitn = TOP_BIT;
                        next_st.ms = M_RXL;
                    end else if (st.ctrl[CTL_ACK]) begin
                        next_st.sda_low = !st.ctrl[CTL_ACK_VALUE]; // [RQ10] [RQ14]
                        next_st.ms = M_AOL;
                    end
                end
                M_RS1: begin
                    if (tick) begin
                        next_st.scl_low = 1'b0;
                        next_st.ms = M_RS2;
                    end
                end
                M_RS2: begin
                    if (tick) begin
                        next_st.sda_low = 1'b1; // [RQ12] [RQ21]
                        next_st.ms = M_START2;
                    end
                end
                M_TXL: begin
                    if (tick) begin
                        next_st.scl_low = 1'b0; // [RQ11]
                        next_st.ms = M_TXH;
                    end
                end
                M_TXH: begin
                    if (tick) begin
                        next_st.scl_low = 1'b1;
                        next_st.sh = {st.sh[6:0], 1'b0};
                        if (st.bitn == 3'h0) begin
                            next_st.sda_low = 1'b0; // [RQ13]
                            next_st.ms = M_AKL;
                        end else begin
                            next_st.bitn = st.bitn - 3'h1;
                            next_st.sda_low = !st.sh[6]; // [RQ18]
                            next_st.ms = M_TXL;
                        end
                    end
                end
                M_AKL: begin
                    if (tick) begin
                        next_st.scl_low = 1'b0;
                        next_st.ms = M_AKH;
                    end
                end
                M_AKH: begin
                    if (tick) begin
                        next_st.ackstat = pins_i.sda; // [RQ13]
                        next_st.scl_low = 1'b1;
                        next_st.transmit_in_progress = 1'b0; // [RQ19]
                        next_st.mev = 1'b1; // [RQ1]
                        next_st.ms = M_WAIT;
                    end
                end
                M_RXL: begin
                    if (tick) begin
                        next_st.scl_low = 1'b0;
                        next_st.ms = M_RXH;
                    end
                end
                M_RXH: begin
                    if (tick) begin
                        next_st.sh = {st.sh[6:0], pins_i.sda};
                        next_st.scl_low = 1'b1;
                        if (st.bitn == 3'h0) begin
                            next_st.ctrl[CTL_RECV] = 1'b0;
                            next_st.ms = M_WAIT;
                        end else begin
                            next_st.bitn = st.bitn - 3'h1;
                            next_st.ms = M_RXL;
                        end
                    end
                end
                M_AOL: begin
                    if (tick) begin
                        next_st.scl_low = 1'b0;
                        next_st.ms = M_AOH;
                    end
                end
                M_AOH: begin
                    if (tick) begin
                        next_st.scl_low = 1'b1;
                        next_st.ctrl[CTL_ACK] = 1'b0;
                        next_st.mev = 1'b1; // [RQ1]
                        next_st.ms = M_WAIT;
                    end
                end
                M_SP1: begin
                    if (tick) begin
                        next_st.scl_low = 1'b0;
                        next_st.ms = M_SP2;
                    end
                end
                M_SP2: begin
                    if (tick) begin
                        next_st.sda_low = 1'b0; // [RQ21]
                        next_st.ms = M_SP3;
                    end
                end
                M_SP3: begin
                    if (tick) begin
                        next_st.ctrl[CTL_STOP] = 1'b0;
                        next_st.owns_bus = 1'b0; // [RQ12]
                        next_st.mev = 1'b1; // [RQ1]
                        next_st.ms = M_IDLE;
                    end
                end
                default: next_st.ms = M_IDLE;
            endcase
        end
        // A received byte lands in the buffer once the last bit is in.
        if (st.ms == M_RXH && tick && st.bitn == 3'h0) begin
            next_st.rcv = {st.sh[6:0], pins_i.sda};
            next_st.receive_full_flag = 1'b1;
            next_st.mev = 1'b1; // [RQ1]
        end

        // Slave address recognition watches the lines only while another
        // master owns the bus; it answers the address byte and no more.
        next_st.scl_d = pins_i.scl;
        next_st.sda_d = pins_i.sda;
        bus_start = st.scl_d && pins_i.scl && st.sda_d && !pins_i.sda;
        bus_stop = st.scl_d && pins_i.scl && !st.sda_d && pins_i.sda;
        scl_rise = !st.scl_d && pins_i.scl;
        scl_fall = st.scl_d && !pins_i.scl;
        match_gc = st.ctrl[CTL_GCALL_EN] && st.rsr == GENERAL_CALL_ADDR; // [RQ5] [RQ6]
        match_own = st.rsr[7:1] == st.own || st.ctrl[CTL_ALL_ADDR]; // [RQ4]
        if (!st.ctrl[CTL_ENABLE] || st.owns_bus || bus_stop) begin
            next_st.sl_act = 1'b0;
            next_st.sl_ack = 1'b0;
        end else if (bus_start) begin
            next_st.sl_act = 1'b1; // [RQ7]
            next_st.sl_cnt = 4'h0;
            next_st.sl_ack = 1'b0;
        end else if (st.sl_act) begin
            if (scl_rise && st.sl_cnt < ADDR_BITS) begin
                next_st.rsr = {st.rsr[6:0], pins_i.sda}; // [RQ7]
                next_st.sl_cnt = st.sl_cnt + 4'h1;
            end else if (scl_fall && st.sl_cnt == ADDR_BITS) begin
                next_st.sl_cnt = ACK_SLOT;
                next_st.sl_hit = match_gc || match_own;
                next_st.sl_gc = match_gc;
                if (match_gc || match_own) begin
                    next_st.rcv = st.rsr; // [RQ8]
                    next_st.receive_full_flag = 1'b1; // [RQ8]
                    next_st.sl_ack = 1'b1;
                end
            end else if (scl_fall && st.sl_cnt == ACK_SLOT) begin
                next_st.sl_ack = 1'b0;
                next_st.sl_act = 1'b0;
                if (st.sl_hit && st.sl_gc) begin
                    next_st.mev = 1'b1; // [RQ8]
                    next_st.gcall = 1'b1;
                end else if (st.sl_hit) begin
                    next_st.sev = 1'b1; // [RQ2]
                end
            end
        end
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.own <= OWN_RESET;
            st.brg <= BRG_RESET;
            st.ms <= M_IDLE;
            st.scl_d <= 1'b1;
            st.sda_d <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign readdata = st.rdata;
    assign waitrequest = (av_req.read || av_req.write) && !st.ack;
    assign pins_o.scl_o = 1'b0;
    assign pins_o.scl_oe = st.scl_low; // [RQ11]
    assign pins_o.sda_o = 1'b0;
    assign pins_o.sda_oe = st.sda_low || st.sl_ack;
    assign pins_o.slew_limit = !st.ctrl[CTL_SLEW_DIS]; // [RQ3]

endmodule // i2c_ctrl

// file: shared/i2c_pkg.sv
// Shared constants and types for the two-wire bus controller.
// Assumes a single 250 MHz clock and an Avalon-MM register slave.
package i2c_pkg;

    // ********************************
    // Register map, byte addresses
    // ********************************
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_STAT = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_OWN = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_TRN = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_RCV = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_BRG = 5'h14;

    // ********************************
    // Control register fields
    // ********************************
    localparam int CTL_START = 0;
    localparam int CTL_RESTART = 1;
    localparam int CTL_STOP = 2;
    localparam int CTL_RECV = 3;
    localparam int CTL_ACK = 4;
    localparam int CTL_ACK_VALUE = 5;
    localparam int CTL_GCALL_EN = 7;
    localparam int CTL_SLEW_DIS = 9;
    localparam int CTL_ALL_ADDR = 11;
    localparam int CTL_ENABLE = 15;

    // ********************************
    // Status register fields
    // ********************************
    localparam int ST_TX_FULL = 0;
    localparam int ST_RX_FULL = 1;
    localparam int ST_MASTER_EV = 2;
    localparam int ST_SLAVE_EV = 3;
    localparam int ST_GCALL = 4;
    localparam int ST_TX_BUSY = 14;
    localparam int ST_ACK_SEEN = 15;

    // ********************************
    // Values and timing
    // ********************************
    localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [6:0] OWN_RESET = 7'h00;
    localparam int CLK_KHZ = 250000;
    localparam int FAST_KHZ = 400;
    localparam int BRG_W = 16;
    // Half bit period minus one, for 400 kHz at the system clock.
    localparam logic [BRG_W-1:0] BRG_RESET = BRG_W'(CLK_KHZ / (2 * FAST_KHZ) - 1);
    localparam logic [3:0] ADDR_BITS = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    localparam logic [2:0] TOP_BIT = 3'h7;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [4:0] {
        M_IDLE, M_START1, M_START2, M_WAIT, M_RS1, M_RS2,
        M_TXL, M_TXH, M_AKL, M_AKH, M_RXL, M_RXH,
        M_AOL, M_AOH, M_SP1, M_SP2, M_SP3
    } mst_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } av_req_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } pins_in_t;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
        logic slew_limit;
    } pins_out_t;

endpackage

// file: verif/i2c_bus_model.sv
// Bus model: pull-ups, line resolution and one addressable target.
// Assumes open-drain enables from the controller and a foreign driver.
`timescale 1ns/1ps
module i2c_bus_model import i2c_pkg::*; #(
    parameter logic [6:0] ADDR = 7'h50,
    parameter logic [7:0] RD = 8'hc3
) (
    // Clock
    input wire logic mclk,
    // Enables, high pulls the line low
    input wire pins_out_t dut_o,
    input wire logic f_scl,
    input wire logic f_sda,
    // Resolved lines and last byte seen
    output pins_in_t pins,
    output logic [7:0] rx_byte = 8'h00
);
    logic s_oe = 1'b0, act = 1'b0, adr = 1'b0, rd = 1'b0;
    logic scl_q = 1'b1, sda_q = 1'b1;
    logic [3:0] bit_n = 4'h0;
    logic [7:0] sh = 8'h00;
    // Released lines float up, so a stale level never lingers.
    assign pins.scl = !(dut_o.scl_oe | f_scl);
    assign pins.sda = !(dut_o.sda_oe | f_sda | s_oe);
    always @(posedge mclk) begin
        scl_q <= pins.scl;
        sda_q <= pins.sda;
        if (pins.scl && scl_q && sda_q && !pins.sda) begin
            {act, adr, rd, s_oe, bit_n} <= 8'hc0;
        end else if (pins.scl && scl_q && !sda_q && pins.sda) begin
            {act, s_oe} <= 2'b00;
        end else if (act && pins.scl && !scl_q) begin
            sh <= {sh[6:0], pins.sda};
            bit_n <= bit_n + 4'h1;
        end else if (act && !pins.scl && scl_q) begin
            if (bit_n == 4'h9) begin
                bit_n <= 4'h0;
                s_oe <= rd & !RD[7];
            end else if (bit_n == 4'h8) begin
                rx_byte <= sh;
                act <= !adr || sh[7:1] == ADDR;
                s_oe <= adr ? sh[7:1] == ADDR : !rd;
                rd <= adr ? sh[0] : rd;
                adr <= 1'b0;
            end else begin
                s_oe <= rd & !RD[3'(7 - bit_n)];
            end
        end
    end
endmodule // i2c_bus_model

// file: verif/i2c_ctrl_sva.sv
// Checker for the register handshake and the bus line drivers.
// Assumes pull-ups on both lines and the bus period register set to 1.
`timescale 1ns/1ps
module i2c_ctrl_sva import i2c_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register bus
    input wire av_req_t av_req,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Bus pins
    input wire pins_in_t pins_i,
    input wire pins_out_t pins_o
);
    logic req;
    assign req = av_req.read | av_req.write;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_wait_first: assert property ($rose(req) |-> waitrequest) else $error("no wait cycle");
    a_wait_once: assert property (req && waitrequest |=> !waitrequest) else $error("wait too long");
    a_slew_follows: assert property (av_req.write && !waitrequest && av_req.address == OFF_CTRL
        && av_req.byteenable[1] |=> pins_o.slew_limit == !$past(av_req.writedata[9])) else $error("slew");
    a_clock_low_min: assert property ($rose(pins_o.scl_oe) |-> pins_o.scl_oe [*2])
        else $error("short low phase");
    a_clock_high_min: assert property ($fell(pins_o.scl_oe) |-> !pins_o.scl_oe [*2])
        else $error("short high phase");
    a_data_on_low: assert property ($fell(pins_o.scl_oe) |-> $stable(pins_o.sda_oe))
        else $error("data moved with clock");
    a_start_shape: assert property ($rose(pins_o.sda_oe) && pins_i.scl && !pins_o.scl_oe
        |-> pins_o.sda_oe throughout (##[1:600] pins_o.scl_oe)) else $error("bad start");
    a_stop_release: assert property ($fell(pins_o.sda_oe) && pins_i.scl && !pins_o.scl_oe
        |=> (!pins_o.sda_oe && !pins_o.scl_oe) [*4]) else $error("bad stop");
endmodule // i2c_ctrl_sva

bind i2c_ctrl i2c_ctrl_sva i2c_ctrl_sva_i (.mclk(mclk), .rst_n(rst_n), .av_req(av_req),
    .readdata(readdata), .waitrequest(waitrequest), .pins_i(pins_i), .pins_o(pins_o));

// file: verif/testbench.sv
// Self-checking bench for the two-wire bus controller.
// Assumes the bus model and the bound checker from this folder.
`timescale 1ns/1ps
`define C(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench import i2c_pkg::*;;
    typedef struct packed {logic [31:0] ctrl; logic [7:0] b; logic ack; logic [2:0] ev;} row_t;
    localparam logic [31:0] ENA = 32'h8200;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    av_req_t av = '0;
    logic [31:0] readdata;
    logic waitrequest;
    pins_in_t pins_i;
    pins_out_t pins_o;
    logic f_scl = 1'b0, f_sda = 1'b0;
    logic [7:0] rx_byte;
    logic [31:0] q;
    logic ack;
    int fail_count = 0;
    int tests_run = 0;
    logic [4:0] r_addr[7] = '{OFF_CTRL, OFF_STAT, OFF_OWN, OFF_TRN, OFF_RCV, OFF_BRG, 5'h18};
    logic [15:0] r_val[7] = '{5: BRG_RESET, default: 16'h0};
    row_t rows[5] = '{'{32'h8200, 8'h54, 1'b0, 3'h2}, '{32'h8200, 8'h00, 1'b1, 3'h0},
        '{32'h8280, 8'h00, 1'b0, 3'h5}, '{32'h8280, 8'h01, 1'b1, 3'h0}, '{32'h8a00, 8'h66, 1'b0, 3'h2}};
    always #2 mclk = ~mclk;
    i2c_ctrl i2c_ctrl_i (.mclk(mclk), .rst_n(rst_n), .av_req(av), .readdata(readdata),
        .waitrequest(waitrequest), .pins_i(pins_i), .pins_o(pins_o));
    i2c_bus_model i2c_bus_model_i (.mclk(mclk), .dut_o(pins_o), .f_scl(f_scl), .f_sda(f_sda),
        .pins(pins_i), .rx_byte(rx_byte));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        av <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
        do @(posedge mclk); while (waitrequest !== 1'b0);
        q = readdata;
        av.read <= 1'b0;
        av.write <= 1'b0;
    endtask
    task automatic wait_ev;
        do bus(1'b0, OFF_STAT, '0); while (q[ST_MASTER_EV] !== 1'b1);
        bus(1'b1, OFF_STAT, 32'h1c);
        bus(1'b0, OFF_STAT, '0);
        `C("event cleared", 1'b0, q[ST_MASTER_EV])
    endtask
    task automatic cmd(input logic [31:0] c);
        bus(1'b1, OFF_CTRL, ENA | c);
        wait_ev;
    endtask
    task automatic send(input logic [7:0] b, input logic nack);
        bus(1'b1, OFF_TRN, {24'h0, b});
        bus(1'b0, OFF_STAT, '0);
        `C("transmit busy", 1'b1, q[ST_TX_BUSY])
        wait_ev;
        `C("ack level", nack, q[ST_ACK_SEEN])
        `C("byte on wire", b, rx_byte)
    endtask
    // Foreign master sending one address byte, four clocks per half bit.
    task automatic fm(input logic [7:0] b, output logic ack);
        @(posedge mclk);
        f_sda <= 1'b1;
        repeat (4) @(posedge mclk);
        f_scl <= 1'b1;
        for (int j = 0; j < 9; j++) begin
            repeat (2) @(posedge mclk);
            f_sda <= (j < 8) ? !b[7 - j] : 1'b0;
            repeat (2) @(posedge mclk);
            f_scl <= 1'b0;
            repeat (4) @(posedge mclk);
            if (j == 8) ack = pins_i.sda;
            f_scl <= 1'b1;
        end
        repeat (2) @(posedge mclk);
        f_sda <= 1'b1;
        repeat (2) @(posedge mclk);
        f_scl <= 1'b0;
        repeat (4) @(posedge mclk);
        f_sda <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    initial begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        finish_test;
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, r_addr[i], '0);
            `C("reset value", {16'h0, r_val[i]}, q)
        end
        $display("reset values done");
        bus(1'b1, OFF_BRG, 32'h1);
        bus(1'b1, OFF_OWN, 32'h2a);
        bus(1'b1, OFF_CTRL, ENA);
        @(posedge mclk);
        `C("slew limit", 1'b0, pins_o.slew_limit)
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, OFF_CTRL, rows[i].ctrl);
            fm(rows[i].b, ack);
            `C("address ack", rows[i].ack, ack)
            bus(1'b0, OFF_STAT, '0);
            `C("address flags", {rows[i].ev, !rows[i].ack}, q[4:1])
            bus(1'b0, OFF_RCV, '0);
            if (!rows[i].ack) `C("receive buffer", rows[i].b, q[7:0])
            bus(1'b1, OFF_STAT, 32'h1c);
        end
        $display("address match done");
        cmd(32'h1);
        send(8'ha0, 1'b0);
        send(8'h3c, 1'b0);
        cmd(32'h2);
        send(8'ha1, 1'b0);
        cmd(32'h8);
        bus(1'b0, OFF_RCV, '0);
        `C("received byte", 8'hc3, q[7:0])
        cmd(32'h10);
        cmd(32'h4);
        `C("lines released", 2'b00, {pins_o.scl_oe, pins_o.sda_oe})
        cmd(32'h1);
        send(8'h40, 1'b1);
        cmd(32'h4);
        $display("master done");
        finish_test;
    end
endmodule // testbench
